// ### rtl/afx_host.sv
// Host controller that drives an asynchronous 9-bit FIFO through its pins.
//
// Overview of operation
// - Standalone ties expansion input low; chained devices take previous expansion output.
// - In a chain only the first device has first-load held low.
// - In a chain each expansion output feeds the next expansion input.
// - In a chain empty flags and full flags are combined externally.
// - Width expansion wires controls in parallel; flags come from any device.
// - Writer toggles write strobe only while full is inactive.
// - Both strobes stay high around the rising edge of reset.
// - Writer watches full, reader watches empty.
`timescale 1ns/100ps
`default_nettype none
module afx_host
  import afx_pkg::*;
#(
  parameter bit STANDALONE   = 1'b1,
  parameter bit FIRST_DEVICE = 1'b1
)
(
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic              wr_req_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic              rd_req_i,
  input  wire logic              rt_req_i,
  input  wire logic              full_n_i,
  input  wire logic              empty_n_i,
  input  wire logic              expand_out_or_half_full_i,
  input  wire logic [DATA_W-1:0] data_out_bus_i,
  output logic                   ready_o,
  output logic                   wr_ack_o,
  output logic                   rd_valid_o,
  output logic [DATA_W-1:0]      rd_data_o,
  output logic                   full_o,
  output logic                   empty_o,
  output logic                   half_full_o,
  output logic                   write_n_o,
  output logic                   read_n_o,
  output logic [DATA_W-1:0]      data_in_bus_o,
  output logic                   reset_in_n_o,
  output logic                   first_load_or_retransmit_n_o,
  output logic                   expansion_in_n_o
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    afx_state_t        st;
    afx_phase_t        ph;
    logic              ready;
    logic              wr_ack;
    logic              rd_valid;
    logic [DATA_W-1:0] rd_data;
    logic              full;
    logic              empty;
    logic              half;
    logic              wr_n;
    logic              rd_n;
    logic [DATA_W-1:0] din;
    logic              rs_n;
    logic              flrt_n;
  } afx_host_st_t;

  // Outside a chain the shared pin is retransmit and idles high; in a chain
  // it is first-load, low only on the head device.
  localparam logic FLRT_IDLE = STANDALONE ? 1'b1 : !FIRST_DEVICE;

  localparam afx_host_st_t RST_VAL = '{
    st: S_RST, ph: P_ARM, ready: 1'b0, wr_ack: 1'b0, rd_valid: 1'b0,
    rd_data: '0, full: 1'b0, empty: 1'b1, half: 1'b0, wr_n: 1'b1,
    rd_n: 1'b1, din: '0, rs_n: 1'b0, flrt_n: FLRT_IDLE};

  afx_host_st_t s_r;
  afx_host_st_t s_nxt;
  afx_tmr_if    tif ();

  afx_timer u_timer (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .tif     (tif)
  );

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  always_comb
  begin
    s_nxt          = s_r;
    s_nxt.wr_ack   = 1'b0;
    s_nxt.rd_valid = 1'b0;
    tif.load       = 1'b0;
    tif.value      = '0;
    // Flags are only trusted once the device has left reset.
    if (s_r.st != S_RST)
    begin
      // One device is watched; composite flags of a chain or a wide array
      // are formed outside and brought in on these same pins.
      s_nxt.full  = !full_n_i;
      s_nxt.empty = !empty_n_i;
      // The shared pin carries the expansion pulse in a chain, so no half-full there.
      s_nxt.half  = STANDALONE && !expand_out_or_half_full_i;
    end
    unique case (s_r.st)
      S_RST:
      begin
        unique case (s_r.ph)
          P_ARM:
          begin
            tif.load  = 1'b1;
            tif.value = CNT_W'(RS_LOW_CYC - 1);
            s_nxt.ph  = P_LOW;
          end
          P_LOW:
          begin
            if (tif.zero)
            begin
              // Strobes are already high and stay so through recovery.
              s_nxt.rs_n = 1'b1;
              tif.load   = 1'b1;
              tif.value  = CNT_W'(REC_CYC - 1);
              s_nxt.ph   = P_REC;
            end
          end
          default:
          begin
            if (tif.zero)
            begin
              s_nxt.st    = S_IDLE;
              s_nxt.ph    = P_ARM;
              s_nxt.ready = 1'b1;
            end
          end
        endcase
      end
      S_IDLE:
      begin
        // Write first, then read, then retransmit; write waits on full, read on empty, retransmit on no flag.
        if (wr_req_i && full_n_i)
        begin
          s_nxt.st    = S_WR;
          s_nxt.ph    = P_LOW;
          s_nxt.ready = 1'b0;
          s_nxt.wr_n  = 1'b0;
          s_nxt.din   = wr_data_i;
          tif.load    = 1'b1;
          tif.value   = CNT_W'(WR_LOW_CYC - 1);
        end
        else if (rd_req_i && empty_n_i)
        begin
          s_nxt.st    = S_RD;
          s_nxt.ph    = P_LOW;
          s_nxt.ready = 1'b0;
          s_nxt.rd_n  = 1'b0;
          tif.load    = 1'b1;
          tif.value   = CNT_W'(RD_LOW_CYC - 1);
        end
        else if (rt_req_i && STANDALONE)
        begin
          s_nxt.st     = S_RT;
          s_nxt.ph     = P_LOW;
          s_nxt.ready  = 1'b0;
          s_nxt.flrt_n = 1'b0;
          tif.load     = 1'b1;
          tif.value    = CNT_W'(RT_LOW_CYC - 1);
        end
      end
      default:
      begin
        if (s_r.ph == P_LOW && tif.zero)
        begin
          // The word is latched by the device at this rising edge.
          if (s_r.st == S_WR)
          begin
            s_nxt.wr_ack = 1'b1;
          end
          // Bus is only valid while the read strobe is low.
          if (s_r.st == S_RD)
          begin
            s_nxt.rd_data  = data_out_bus_i;
            s_nxt.rd_valid = 1'b1;
          end
          s_nxt.wr_n   = 1'b1;
          s_nxt.rd_n   = 1'b1;
          s_nxt.flrt_n = FLRT_IDLE;
          s_nxt.ph     = P_REC;
          tif.load     = 1'b1;
          tif.value    = CNT_W'(REC_CYC - 1);
        end
        else if (s_r.ph != P_LOW && tif.zero)
        begin
          s_nxt.st    = S_IDLE;
          s_nxt.ph    = P_ARM;
          s_nxt.ready = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      s_r <= RST_VAL;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign ready_o                      = s_r.ready;
  assign wr_ack_o                     = s_r.wr_ack;
  assign rd_valid_o                   = s_r.rd_valid;
  assign rd_data_o                    = s_r.rd_data;
  assign full_o                       = s_r.full;
  assign empty_o                      = s_r.empty;
  assign half_full_o                  = s_r.half;
  assign write_n_o                    = s_r.wr_n;
  assign read_n_o                     = s_r.rd_n;
  assign data_in_bus_o                = s_r.din;
  assign reset_in_n_o                 = s_r.rs_n;
  assign first_load_or_retransmit_n_o = s_r.flrt_n;
  // Constant pin; driven low when standalone, driven high in a chain, where the device takes the prior device's expansion output.
  assign expansion_in_n_o             = !STANDALONE;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  AST_WR_NOT_FULL: assert property (@(posedge clock_i) disable iff (rst_i)
    $fell(write_n_o) |-> $past(full_n_i)) else $error("Write began on full.");
  AST_RD_NOT_EMPTY: assert property (@(posedge clock_i) disable iff (rst_i)
    $fell(read_n_o) |-> $past(empty_n_i)) else $error("Read began on empty.");
  AST_RS_STROBES_HIGH: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(reset_in_n_o) |-> (write_n_o && read_n_o)[*3])
    else $error("Strobe moved around reset release.");
  AST_WR_WIDTH: assert property (@(posedge clock_i) disable iff (rst_i)
    $fell(write_n_o) |-> !write_n_o[*8] ##1 write_n_o)
    else $error("Write strobe width wrong.");
  AST_WR_ACK: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(write_n_o) |-> wr_ack_o) else $error("Write ack not at strobe rise.");
  AST_RD_SAMPLE: assert property (@(posedge clock_i) disable iff (rst_i)
    rd_valid_o |-> $past(!read_n_o, 1) && read_n_o) else $error("Read sampled off strobe.");
  AST_RT_QUIET: assert property (@(posedge clock_i) disable iff (rst_i)
    (STANDALONE && !first_load_or_retransmit_n_o) |-> (write_n_o && read_n_o))
    else $error("Strobe active during retransmit.");
  AST_NO_RT_CHAIN: assert property (@(posedge clock_i) disable iff (rst_i)
    !STANDALONE |-> (first_load_or_retransmit_n_o == !FIRST_DEVICE) && !half_full_o)
    else $error("Retransmit or half-full used in a chain.");
  AST_ONE_STROBE: assert property (@(posedge clock_i) disable iff (rst_i)
    !(!write_n_o && !read_n_o)) else $error("Both strobes low.");

endmodule
`default_nettype wire

// ### rtl/afx_pkg.sv
// Shared constants and types for the asynchronous FIFO host controller.
package afx_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int DATA_W = 9;
  localparam int CNT_W  = 4;

  // ---------------------------------------------------------------------------
  // Times in ns and their cycle counts at 250 MHz
  // ---------------------------------------------------------------------------
  localparam int CLK_NS        = 4;
  localparam int WR_LOW_NS     = 30;
  localparam int RD_LOW_NS     = 30;
  localparam int REC_NS        = 10;
  localparam int RS_LOW_NS     = 30;
  localparam int RT_LOW_NS     = 30;
  // Least times, so each count rounds up.
  localparam int WR_LOW_CYC    = (WR_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_LOW_CYC    = (RD_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int REC_CYC       = (REC_NS + CLK_NS - 1) / CLK_NS;
  localparam int RS_LOW_CYC    = (RS_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int RT_LOW_CYC    = (RT_LOW_NS + CLK_NS - 1) / CLK_NS;

  // ---------------------------------------------------------------------------
  // Controller states and strobe phases
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    S_RST  = 3'h0,
    S_IDLE = 3'h1,
    S_WR   = 3'h3,
    S_RD   = 3'h2,
    S_RT   = 3'h6
  } afx_state_t;

  typedef enum logic [1:0] {
    P_ARM = 2'h0,
    P_LOW = 2'h1,
    P_REC = 2'h3
  } afx_phase_t;

endpackage

// ### rtl/afx_timer.sv
// Down counter that times the low and recovery phases of the strobes.
`timescale 1ns/100ps
`default_nettype none
module afx_timer
  import afx_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic rst_i,
  afx_tmr_if.tmr    tif
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } afx_tmr_st_t;

  afx_tmr_st_t st_r;
  afx_tmr_st_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (tif.load)
    begin
      st_nxt.cnt = tif.value;
    end
    else if (st_r.cnt != '0)
    begin
      st_nxt.cnt = st_r.cnt - CNT_W'(1);
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign tif.zero = (st_r.cnt == '0);

  AST_TMR_COUNTS_DOWN: assert property (@(posedge clock_i) disable iff (rst_i)
    (!tif.load && st_r.cnt != '0) |=> (st_r.cnt == $past(st_r.cnt) - CNT_W'(1)))
    else $error("Phase timer did not count down.");

endmodule
`default_nettype wire

// ### rtl/afx_tmr_if.sv
// Load and expiry signals between the controller and its phase timer.
`timescale 1ns/100ps
`default_nettype none
interface afx_tmr_if;
  import afx_pkg::*;
  logic             load;
  logic [CNT_W-1:0] value;
  logic             zero;
  modport ctl (output load, output value, input zero);
  modport tmr (input load, input value, output zero);
endinterface
`default_nettype wire

// ### testbench/afx_dev_model.sv
// Behavioural model of the asynchronous 9-bit FIFO device driven by the host.
`timescale 1ns/100ps
`default_nettype none
module afx_dev_model
  import afx_pkg::*;
#(
  parameter int DEPTH = 256
)
(
  input  wire logic              write_n_i,
  input  wire logic              read_n_i,
  input  wire logic              reset_in_n_i,
  input  wire logic              first_load_or_retransmit_n_i,
  input  wire logic              expansion_in_n_i,
  input  wire logic [DATA_W-1:0] data_in_bus_i,
  output logic                   full_n_o,
  output logic                   empty_n_o,
  output logic                   expand_out_or_half_full_o,
  output logic [DATA_W-1:0]      data_out_bus_o
);
  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] last_q = '0;
  int                wptr = 0;
  int                rptr = 0;
  int                cnt = 0;
  logic              wr_go = 1'b0;
  logic              rd_go = 1'b0;
  logic              pw = 1'b1;
  logic              pr = 1'b1;
  logic              prt = 1'b1;

  // ---------------------------------------------------------------------------
  // Strobe edges
  // ---------------------------------------------------------------------------
  always @(write_n_i or read_n_i or reset_in_n_i or first_load_or_retransmit_n_i)
  begin
    if (!reset_in_n_i)
    begin
      wptr = 0;
      rptr = 0;
      cnt = 0;
      wr_go = 1'b0;
      rd_go = 1'b0;
    end
    else
    begin
      if (pw && !write_n_i)
        wr_go = (cnt < DEPTH);
      if (!pw && write_n_i && wr_go)
      begin
        mem[wptr] = data_in_bus_i;
        wptr = (wptr + 1) % DEPTH;
        cnt = cnt + 1;
        wr_go = 1'b0;
      end
      if (pr && !read_n_i)
        rd_go = (cnt > 0);
      if (!pr && read_n_i && rd_go)
      begin
        last_q = mem[rptr];
        rptr = (rptr + 1) % DEPTH;
        cnt = cnt - 1;
        rd_go = 1'b0;
      end
      if (prt && !first_load_or_retransmit_n_i && !expansion_in_n_i)
      begin
        rptr = 0;
        cnt = wptr;
      end
    end
    pw = write_n_i;
    pr = read_n_i;
    prt = first_load_or_retransmit_n_i;
  end

  // Flags that a strobe sets move at its falling edge, ahead of the count.
  assign full_n_o = !(cnt == DEPTH || (wr_go && cnt == DEPTH - 1));
  assign empty_n_o = !(cnt == 0 || (rd_go && cnt == 1));
  assign expand_out_or_half_full_o =
    !(cnt > DEPTH / 2 || (wr_go && cnt == DEPTH / 2));
  // A floating bus shows the inverse of the last word, never a stale copy.
  assign data_out_bus_o = read_n_i ? ~last_q : mem[rptr];
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the FIFO host controller against the device model.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import afx_pkg::*;
  localparam int DEPTH = 256;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr_req_i = 1'b0;
  logic rd_req_i = 1'b0;
  logic rt_req_i = 1'b0;
  logic [DATA_W-1:0] wr_data_i = '0;
  logic full_n, empty_n, hf_n, ready_o, wr_ack_o, rd_valid_o;
  logic full_o, empty_o, half_full_o, write_n, read_n, rst_n, flrt_n, xin_n;
  logic [DATA_W-1:0] q_bus, d_bus, rd_data_o;
  int err_count = 0;
  int check_count = 0;
  int ack_seen = 0;
  int val_seen = 0;

  always #2 clock_i = ~clock_i;

  // Pulses are counted at the falling edge, half a cycle after they are launched.
  always @(negedge clock_i)
  begin
    ack_seen += int'(wr_ack_o);
    val_seen += int'(rd_valid_o);
  end

  afx_host afx_host_inst (.clock_i(clock_i), .rst_i(rst_i), .wr_req_i(wr_req_i),
    .wr_data_i(wr_data_i), .rd_req_i(rd_req_i), .rt_req_i(rt_req_i),
    .full_n_i(full_n), .empty_n_i(empty_n), .expand_out_or_half_full_i(hf_n),
    .data_out_bus_i(q_bus), .ready_o(ready_o), .wr_ack_o(wr_ack_o),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .full_o(full_o),
    .empty_o(empty_o), .half_full_o(half_full_o), .write_n_o(write_n),
    .read_n_o(read_n), .data_in_bus_o(d_bus), .reset_in_n_o(rst_n),
    .first_load_or_retransmit_n_o(flrt_n), .expansion_in_n_o(xin_n));

  afx_dev_model #(.DEPTH(DEPTH)) afx_dev_model_inst (.write_n_i(write_n),
    .read_n_i(read_n), .reset_in_n_i(rst_n), .first_load_or_retransmit_n_i(flrt_n),
    .expansion_in_n_i(xin_n), .data_in_bus_i(d_bus), .full_n_o(full_n),
    .empty_n_o(empty_n), .expand_out_or_half_full_o(hf_n), .data_out_bus_o(q_bus));

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic end_sim;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic wait_rdy(input logic val);
    int n;
    for (n = 0; n < 40 && ready_o !== val; n++)
      @(negedge clock_i);
    if (n == 40)
      chk(9'(ready_o), 9'(val));
  endtask

  function automatic logic [DATA_W-1:0] wd(input int i);
    return 9'(i * 37 + 5);
  endfunction

  // Kind 0 writes, 1 reads, 2 retransmits; returns once the host is idle again.
  task automatic op(input int kind, input logic [DATA_W-1:0] d);
    int a0;
    int v0;
    a0 = ack_seen;
    v0 = val_seen;
    wr_data_i = d;
    wr_req_i = (kind == 0);
    rd_req_i = (kind == 1);
    rt_req_i = (kind == 2);
    wait_rdy(1'b0);
    wr_req_i = 1'b0;
    rd_req_i = 1'b0;
    rt_req_i = 1'b0;
    wait_rdy(1'b1);
    chk(9'(ack_seen - a0), 9'(kind == 0));
    chk(9'(val_seen - v0), 9'(kind == 1));
  endtask

  // A request the device flag forbids must leave both strobes idle.
  task automatic refuse(input int kind);
    wr_req_i = (kind == 0);
    rd_req_i = (kind == 1);
    repeat (20) @(negedge clock_i);
    chk(9'({ready_o, write_n, read_n}), 9'h007);
    wr_req_i = 1'b0;
    rd_req_i = 1'b0;
    @(negedge clock_i);
  endtask

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial
  begin
    repeat (4) @(negedge clock_i);
    chk(9'({ready_o, write_n, read_n, rst_n}), 9'h006);
    rst_i = 1'b0;
    wait_rdy(1'b1);
    // Flags reach the outputs one cycle after ready, so look one cycle later.
    @(negedge clock_i);
    chk(9'({empty_o, full_o, half_full_o}), 9'h004);
    chk(9'(xin_n), 9'h000);
    refuse(1);
    for (int i = 0; i < DEPTH; i++)
    begin
      op(0, wd(i));
      if (i == DEPTH / 2 - 1)
        chk(9'(half_full_o), 9'h000);
      if (i == DEPTH / 2)
        chk(9'(half_full_o), 9'h001);
      if (i == DEPTH - 2)
        chk(9'(full_o), 9'h000);
    end
    chk(9'({full_o, empty_o}), 9'h002);
    refuse(0);
    op(1, '0);
    chk(rd_data_o, wd(0));
    chk(9'(full_o), 9'h000);
    op(0, wd(DEPTH));
    chk(9'(full_o), 9'h001);
    for (int i = 1; i <= DEPTH; i++)
    begin
      op(1, '0);
      chk(rd_data_o, wd(i));
      if (i == DEPTH / 2 - 1)
        chk(9'(half_full_o), 9'h001);
      if (i == DEPTH / 2)
        chk(9'(half_full_o), 9'h000);
    end
    chk(9'(empty_o), 9'h001);
    refuse(1);
    op(0, wd(7));
    rst_i = 1'b1;
    repeat (4) @(negedge clock_i);
    chk(9'({ready_o, write_n, read_n, rst_n}), 9'h006);
    rst_i = 1'b0;
    wait_rdy(1'b1);
    @(negedge clock_i);
    chk(9'({empty_o, full_o, half_full_o}), 9'h004);
    for (int i = 0; i < 3; i++)
      op(0, wd(i + 40));
    op(1, '0);
    op(1, '0);
    op(2, '0);
    for (int i = 0; i < 3; i++)
    begin
      op(1, '0);
      chk(rd_data_o, wd(i + 40));
    end
    chk(9'(empty_o), 9'h001);
    end_sim();
  end

  initial
  begin
    repeat (20000) @(posedge clock_i);
    err_count++;
    end_sim();
  end
endmodule
`default_nettype wire
